// ### rtl/region_decode.sv
// ===========================================================================
// Region classification of one flash address.
module region_decode
  import selfprog_pkg::*;
(
  input  wire logic [11:0] addr,
  input  wire logic [1:0]  boot_size,
  output logic             in_boot,
  output logic             in_stall
);
  logic [11:0] base;
  always_comb begin
    case (boot_size)
      2'b00:   base = BOOT_BASE_0;
      2'b01:   base = BOOT_BASE_1;
      2'b10:   base = BOOT_BASE_2;
      default: base = BOOT_BASE_3;
    endcase
    in_boot = (addr >= base);
    in_stall = (addr >= STALL_BASE);
  end
endmodule

// ### rtl/selfprog_flash_section_control.sv
// ===========================================================================
// Self-programming region access control.
module selfprog_flash_section_control
  import selfprog_pkg::*;
(
  input  wire logic        CORE_CLK,
  input  wire logic        RSTN,
  input  wire logic [1:0]  BOOT_SIZE_FUSES,
  input  wire logic [11:0] PC_ADDR,
  input  wire logic        SPI_VALID,
  input  wire logic [1:0]  SPI_OP,
  input  wire logic [11:0] SPI_TARGET,
  input  wire logic        READ_REQ,
  input  wire logic [11:0] READ_ADDR,
  output logic             READ_ALLOW,
  output logic             CPU_HALT,
  output logic             FLASH_START,
  output logic [1:0]       FLASH_OP,
  output logic [11:0]      FLASH_ADDR,
  output logic             BUSY_FLAG,
  output logic             IRQ,
  input  wire logic        WB_CYC_I,
  input  wire logic        WB_STB_I,
  input  wire logic        WB_WE_I,
  input  wire logic [7:0]  WB_ADR_I,
  input  wire logic [3:0]  WB_SEL_I,
  input  wire logic [31:0] WB_DAT_I,
  output logic [31:0]      WB_DAT_O,
  output logic             WB_ACK_O
);
  typedef struct packed {
    state_e           st;
    logic [CNT_W-1:0] cnt;
    logic [CNT_W-1:0] halt_len;
    logic             busy;
    logic             app_lock;
    logic             boot_lock;
    logic [EV_W-1:0]  ev;
    logic [EV_W-1:0]  mask;
    logic             start;
    logic [1:0]       op;
    logic [11:0]      addr;
    logic             ack;
    logic [31:0]      rdata;
  } state_s;
  state_s r;
  state_s n;
  logic pc_boot;
  logic pc_stall;
  logic tg_boot;
  logic tg_stall;
  logic rd_boot;
  logic rd_stall;
  region_decode u_pc (
    .addr      (PC_ADDR),
    .boot_size (BOOT_SIZE_FUSES),
    .in_boot   (pc_boot),
    .in_stall  (pc_stall)
  );
  region_decode u_tg (
    .addr      (SPI_TARGET),
    .boot_size (BOOT_SIZE_FUSES),
    .in_boot   (tg_boot),
    .in_stall  (tg_stall)
  );
  region_decode u_rd (
    .addr      (READ_ADDR),
    .boot_size (BOOT_SIZE_FUSES),
    .in_boot   (rd_boot),
    .in_stall  (rd_stall)
  );
  logic wb_req;
  logic wb_wr;
  logic locked;
  logic accept;
  logic prog;
  logic reject;
  logic done;
  logic [CNT_W-1:0] prog_cnt;
  assign prog_cnt = CNT_W'(PROG_CYCLES - 1);
  assign wb_req = WB_CYC_I && WB_STB_I && !r.ack;
  assign wb_wr = wb_req && WB_WE_I && WB_SEL_I[0];
  // Each region is governed by its own lock bit.
  assign locked = tg_boot ? r.boot_lock : r.app_lock;
  // Boot-loader code may reach any address; application code never programs.
  assign accept = SPI_VALID && pc_boot && (r.st == ST_IDLE);
  assign prog = accept && (SPI_OP == OP_ERASE || SPI_OP == OP_WRITE) && !locked;
  assign reject = SPI_VALID && !(accept && (SPI_OP == OP_LOAD || prog));
  assign done = (r.st != ST_IDLE) && (r.cnt == '0);
  // Named only for the checks.
  logic load_cmd;
  logic reenable_wr;
  assign load_cmd = accept && (SPI_OP == OP_LOAD);
  assign reenable_wr = wb_wr && (WB_ADR_I == REG_CTRL) && WB_DAT_I[CTRL_REENABLE];
  // ===========================================================================
  // Next state.
  always_comb begin
    n = r;
    n.start = 1'b0;
    n.ack = wb_req;
    case (r.st)
      ST_IDLE: begin
        if (prog) begin
          n.cnt = prog_cnt;
          n.st = tg_stall ? ST_HALT : ST_RUN;
          n.busy = r.busy | !tg_stall;
        end
      end
      ST_RUN, ST_HALT: begin
        if (r.cnt == '0) begin
          n.st = ST_IDLE;
        end else begin
          n.cnt = r.cnt - 1'b1;
        end
      end
      default: n.st = ST_IDLE;
    endcase
    // Halt cycles counted apart from cnt, so the checks do not trust the counter they watch.
    n.halt_len = (n.st == ST_HALT) ? r.halt_len + 1'b1 : '0;
    if (accept && (SPI_OP == OP_LOAD || prog)) begin
      n.start = 1'b1;
      n.op = SPI_OP;
      n.addr = SPI_TARGET;
    end
    // The page load clears busy only when nothing is running.
    if (accept && SPI_OP == OP_LOAD) begin
      n.busy = 1'b0;
    end
    if (wb_wr && WB_ADR_I == REG_CTRL) begin
      n.app_lock = WB_DAT_I[CTRL_APP_LOCK];
      n.boot_lock = WB_DAT_I[CTRL_BOOT_LOCK];
      if (WB_DAT_I[CTRL_REENABLE] && r.st == ST_IDLE && !prog) begin
        n.busy = 1'b0;
      end
    end
    if (wb_wr && WB_ADR_I == REG_IRQ_MASK) begin
      n.mask = WB_DAT_I[EV_W-1:0];
    end
    if (wb_wr && WB_ADR_I == REG_IRQ_STAT) begin
      n.ev = r.ev & ~WB_DAT_I[EV_W-1:0];
    end
    // A new event wins over a clear in the same cycle.
    if (done) begin
      n.ev[EV_DONE] = 1'b1;
    end
    if (reject) begin
      n.ev[EV_REJECT] = 1'b1;
    end
    n.rdata = '0;
    if (wb_req && !WB_WE_I) begin
      case (WB_ADR_I)
        REG_CTRL: n.rdata = {29'h0000_0000, r.boot_lock, r.app_lock, 1'b0};
        REG_STAT: n.rdata = {29'h0000_0000, r.st != ST_IDLE, r.st == ST_HALT, r.busy};
        REG_IRQ_STAT: n.rdata = {30'h0000_0000, r.ev};
        REG_IRQ_MASK: n.rdata = {30'h0000_0000, r.mask};
        default: n.rdata = '0;
      endcase
    end
  end
  // ===========================================================================
  // State register.
  always_ff @(posedge CORE_CLK or negedge RSTN) begin
    if (!RSTN) begin
      r <= '{st: ST_IDLE, op: OP_NONE, default: '0};
    end else begin
      r <= n;
    end
  end
  // ===========================================================================
  // Outputs. Page grouping never touches the read path; only region matters.
  assign CPU_HALT = (r.st == ST_HALT);
  assign READ_ALLOW = READ_REQ && !CPU_HALT && (rd_stall || !r.busy);
  assign BUSY_FLAG = r.busy;
  assign FLASH_START = r.start;
  assign FLASH_OP = r.op;
  assign FLASH_ADDR = r.addr;
  assign IRQ = |(r.ev & r.mask);
  assign WB_ACK_O = r.ack;
  assign WB_DAT_O = r.rdata;

  // ===========================================================================
  // Checks: store-program acceptance.

  a_app_ignored: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
    (SPI_VALID && !pc_boot)
    |=> !FLASH_START)
    else $error("program accepted from application");

  a_boot_start: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
    FLASH_START
    |-> ($past(SPI_VALID) && $past(pc_boot)))
    else $error("start without boot origin");

  a_any_target: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
    (prog && tg_boot)
    |=> (FLASH_START && FLASH_ADDR == $past(SPI_TARGET)))
    else $error("boot target refused");

  a_start_addr: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
    FLASH_START
    |-> (FLASH_ADDR == $past(SPI_TARGET)))
    else $error("start address differs from target");

  a_start_op: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
    FLASH_START
    |-> (FLASH_OP == $past(SPI_OP) && FLASH_OP != OP_NONE))
    else $error("start carries wrong operation");

  a_single_op: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
    (SPI_VALID && r.st != ST_IDLE)
    |=> !FLASH_START)
    else $error("start while operation active");

  a_lock_app: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
    (SPI_VALID && !tg_boot && r.app_lock)
    |=> (!FLASH_START || FLASH_OP == OP_LOAD))
    else $error("application lock ignored");

  a_lock_boot: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
    (SPI_VALID && tg_boot && r.boot_lock)
    |=> (!FLASH_START || FLASH_OP == OP_LOAD))
    else $error("boot lock ignored");

  a_reject_flag: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
    reject
    |=> r.ev[EV_REJECT])
    else $error("rejected instruction not flagged");

  // ===========================================================================
  // Checks: region map and timing.
  // A wrong reload of cnt would stretch or cut the halt, so its length is counted apart.

  a_boot_inside: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
    pc_boot
    |-> pc_stall)
    else $error("boot region outside stalling region");

  a_halt_stall: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
    (prog && tg_stall)
    |=> CPU_HALT [*8])
    else $error("stalling program not halting");

  a_halt_origin: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
    $rose(CPU_HALT)
    |-> ($past(prog) && $past(tg_stall)))
    else $error("halt without stalling program");

  a_halt_len: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
    (CPU_HALT && r.cnt == '0)
    |-> (r.halt_len == CNT_W'(PROG_CYCLES)))
    else $error("halt length wrong");

  a_halt_end: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
    (CPU_HALT && r.cnt == '0)
    |=> !CPU_HALT)
    else $error("halt outlasts operation");

  a_halt_busy: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
    (prog && tg_stall)
    |=> (BUSY_FLAG == $past(BUSY_FLAG)))
    else $error("stalling program moved busy");

  a_run_conc: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
    (prog && !tg_stall)
    |=> (!CPU_HALT && BUSY_FLAG) [*8])
    else $error("concurrent program halted");

  // ===========================================================================
  // Checks: read gating.
  // Stalling-region reads must survive a concurrent operation, or the boot loader starves.

  a_block_read: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
    (BUSY_FLAG && !rd_stall)
    |-> !READ_ALLOW)
    else $error("blocked region read");

  a_stall_read: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
    (READ_REQ && rd_stall && !CPU_HALT)
    |-> READ_ALLOW)
    else $error("stalling region read refused");

  a_halt_read: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
    CPU_HALT
    |-> !READ_ALLOW)
    else $error("read during halt");

  a_free_read: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
    (READ_REQ && !CPU_HALT && !BUSY_FLAG)
    |-> READ_ALLOW)
    else $error("idle read refused");

  // ===========================================================================
  // Checks: busy flag.
  // Busy is the only guard software has, so it must not drop while an operation runs.

  a_busy_origin: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
    $rose(BUSY_FLAG)
    |-> ($past(prog) && !$past(tg_stall)))
    else $error("busy set without concurrent program");

  a_busy_release: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
    $fell(BUSY_FLAG)
    |-> ($past(load_cmd) || $past(reenable_wr)))
    else $error("busy cleared without cause");

  a_busy_kept: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
    (reenable_wr && r.st != ST_IDLE && BUSY_FLAG)
    |=> BUSY_FLAG)
    else $error("busy dropped during operation");

  a_load_clear: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
    load_cmd
    |=> !BUSY_FLAG)
    else $error("page load kept busy");

  a_busy_stat: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
    (WB_ACK_O && $past(WB_ADR_I) == REG_STAT && !$past(WB_WE_I))
    |-> (WB_DAT_O[STAT_BUSY] == $past(BUSY_FLAG)))
    else $error("status busy bit wrong");

  // ===========================================================================
  // Checks: register bus and events.

  a_ack_once: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
    WB_ACK_O
    |=> !WB_ACK_O)
    else $error("acknowledge longer than one cycle");

  a_ack_follows: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
    (WB_CYC_I && WB_STB_I && !WB_ACK_O)
    |=> WB_ACK_O)
    else $error("request not acknowledged");

  a_done_flag: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
    done
    |=> r.ev[EV_DONE])
    else $error("finished operation not flagged");

  // ===========================================================================
  // Scenario coverage.
  c_conc: cover property (@(posedge CORE_CLK) disable iff (!RSTN) prog && !tg_stall);
  c_stall: cover property (@(posedge CORE_CLK) disable iff (!RSTN) prog && tg_stall);
  c_reject: cover property (@(posedge CORE_CLK) disable iff (!RSTN) SPI_VALID && !pc_boot);
  c_irq: cover property (@(posedge CORE_CLK) disable iff (!RSTN) $rose(IRQ));
  c_load: cover property (@(posedge CORE_CLK) disable iff (!RSTN) load_cmd);
endmodule

// ### rtl/selfprog_pkg.sv
package selfprog_pkg;
  // ===========================================================================
  // Flash geometry
  localparam int unsigned ADDR_W = 12;
  localparam logic [11:0] STALL_BASE = 12'h0c00;
  // Boot region base per fuse code; every entry sits at or above STALL_BASE.
  localparam logic [11:0] BOOT_BASE_0 = 12'h0c00;
  localparam logic [11:0] BOOT_BASE_1 = 12'h0e00;
  localparam logic [11:0] BOOT_BASE_2 = 12'h0f00;
  localparam logic [11:0] BOOT_BASE_3 = 12'h0f80;
  // ===========================================================================
  // Wishbone register map
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STAT = 8'h04;
  localparam logic [7:0] REG_IRQ_STAT = 8'h08;
  localparam logic [7:0] REG_IRQ_MASK = 8'h0c;
  localparam int unsigned CTRL_REENABLE = 0;
  localparam int unsigned CTRL_APP_LOCK = 1;
  localparam int unsigned CTRL_BOOT_LOCK = 2;
  localparam int unsigned STAT_BUSY = 0;
  localparam int unsigned STAT_HALT = 1;
  localparam int unsigned STAT_ACTIVE = 2;
  localparam int unsigned EV_DONE = 0;
  localparam int unsigned EV_REJECT = 1;
  localparam int unsigned EV_W = 2;
  // ===========================================================================
  // Operations
  typedef enum logic [1:0] {
    OP_LOAD  = 2'b00,
    OP_ERASE = 2'b01,
    OP_WRITE = 2'b10,
    OP_NONE  = 2'b11
  } op_e;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_RUN  = 2'b01,
    ST_HALT = 2'b10
  } state_e;
  localparam int unsigned PROG_TIME_US = 4;
  localparam int unsigned CLK_MHZ = 50;
  localparam int unsigned PROG_CYCLES = PROG_TIME_US * CLK_MHZ;
  localparam int unsigned CNT_W = 8;
endpackage

// ### verif/cpu_fetch_model.sv
// ===========================================================================
// CPU fetch side: issues code reads towards the flash.
module cpu_fetch_model (
  input  wire logic        busy,
  input  wire logic        go,
  input  wire logic        probe,
  input  wire logic [11:0] addr,
  output logic             req,
  output logic [11:0]      req_addr
);
  timeunit 1ns;
  timeprecision 1ps;
  // Software keeps away from the concurrent region while it is busy; probe breaks that on purpose.
  assign req      = go & (probe | !(busy & (addr < 12'h0c00)));
  // An idle address carries the inverse, so a stale value never looks like a request.
  assign req_addr = req ? addr : ~addr;
endmodule

// ### verif/selfprog_flash_section_control_bench.sv
// ===========================================================================
// Self-checking bench for the self-programming access control.
module selfprog_flash_section_control_bench;
  import selfprog_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk, rstn = 1'b0, spi_v = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic        go = 1'b0, probe = 1'b0, rd_req, allow, halt, fstart, busy, irq, ack, v;
  logic [1:0]  fuse = 2'b00, op = 2'b11, fop;
  logic [11:0] pc = 12'h0000, tgt = 12'h0000, ga = 12'h0000, raddr, faddr;
  logic [7:0]  adr = 8'h00;
  logic [31:0] wdat = 32'h0, rdat, q;
  logic [11:0] base [4] = '{BOOT_BASE_0, BOOT_BASE_1, BOOT_BASE_2, BOOT_BASE_3};
  int          mismatches = 0, num_checks = 0;

  selfprog_flash_section_control u_dut (
    .CORE_CLK(clk), .RSTN(rstn), .BOOT_SIZE_FUSES(fuse), .PC_ADDR(pc), .SPI_VALID(spi_v),
    .SPI_OP(op), .SPI_TARGET(tgt), .READ_REQ(rd_req), .READ_ADDR(raddr), .READ_ALLOW(allow),
    .CPU_HALT(halt), .FLASH_START(fstart), .FLASH_OP(fop), .FLASH_ADDR(faddr), .BUSY_FLAG(busy),
    .IRQ(irq), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(4'hf),
    .WB_DAT_I(wdat), .WB_DAT_O(rdat), .WB_ACK_O(ack));
  cpu_fetch_model u_cpu (.busy(busy), .go(go), .probe(probe), .addr(ga), .req(rd_req), .req_addr(raddr));

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // ===========================================================================
  // Shared drivers and comparison.
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected %s: expected %h, seen %h", nm, exp, got);
    end
  endtask

  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do @(posedge clk); while (ack !== 1'b1);
    r = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask

  // Returns whether the flash start pulse followed the instruction.
  task automatic store_program_instruction(input logic [1:0] o, input logic [11:0] p, input logic [11:0] t, output logic fs);
    @(posedge clk);
    spi_v <= 1'b1;
    op <= o;
    pc <= p;
    tgt <= t;
    @(posedge clk);
    spi_v <= 1'b0;
    #1 fs = fstart;
  endtask

  task automatic rd(input logic [11:0] a, input logic pr, output logic al);
    @(posedge clk);
    go <= 1'b1;
    ga <= a;
    probe <= pr;
    #1 al = allow;
    @(posedge clk);
    go <= 1'b0;
  endtask

  // ===========================================================================
  // Scenarios.
  task automatic t_app();
    store_program_instruction(OP_ERASE, 12'h0100, 12'h0200, v);
    chk("app start", v, 1'b0);
    wb(1'b0, REG_IRQ_STAT, 32'h0, q);
    chk("reject stat", q, 32'h0000_0002);
    chk("reject irq", irq, 1'b1);
    wb(1'b1, REG_IRQ_STAT, 32'h0000_0003, q);
    #1 chk("irq clear", irq, 1'b0);
  endtask

  task automatic t_rww();
    store_program_instruction(OP_ERASE, 12'h0c10, 12'h0100, v);
    chk("start", v, 1'b1);
    chk("addr", faddr, 12'h0100);
    chk("op", fop, OP_ERASE);
    chk("busy", busy, 1'b1);
    chk("halt", halt, 1'b0);
    rd(12'h0100, 1'b1, v);
    chk("conc read", v, 1'b0);
    rd(12'h0d00, 1'b0, v);
    chk("stall read", v, 1'b1);
    repeat (210) @(posedge clk);
    chk("busy held", busy, 1'b1);
    wb(1'b0, REG_STAT, 32'h0, q);
    chk("stat busy", q[0], 1'b1);
    chk("done irq", irq, 1'b1);
    wb(1'b1, REG_CTRL, 32'h0000_0001, q);
    #1 chk("reenable", busy, 1'b0);
    rd(12'h0100, 1'b0, v);
    chk("read back", v, 1'b1);
    store_program_instruction(OP_WRITE, 12'h0c10, 12'h0200, v);
    repeat (210) @(posedge clk);
    store_program_instruction(OP_LOAD, 12'h0c10, 12'h0200, v);
    chk("load clear", busy, 1'b0);
    wb(1'b1, REG_IRQ_STAT, 32'h0000_0003, q);
  endtask

  task automatic t_halt();
    fuse <= 2'b11;
    store_program_instruction(OP_WRITE, 12'h0f90, 12'h0f90, v);
    chk("boot self", v, 1'b1);
    chk("halted", halt, 1'b1);
    rd(12'h0d00, 1'b0, v);
    chk("halt read", v, 1'b0);
    wb(1'b0, REG_STAT, 32'h0, q);
    chk("stat halt", q[2:0], 3'b110);
    repeat (150) @(posedge clk);
    chk("halt hold", halt, 1'b1);
    repeat (60) @(posedge clk);
    chk("halt end", halt, 1'b0);
    chk("no busy", busy, 1'b0);
  endtask

  task automatic t_fuse();
    for (int i = 0; i < 4; i++) begin
      @(posedge clk);
      fuse <= 2'(i);
      store_program_instruction(OP_LOAD, base[i] - 12'h001, 12'h0100, v);
      chk("below base", v, 1'b0);
      store_program_instruction(OP_LOAD, base[i], 12'h0100, v);
      chk("at base", v, 1'b1);
    end
  endtask

  task automatic t_lock();
    wb(1'b1, REG_CTRL, 32'h0000_0002, q);
    store_program_instruction(OP_ERASE, 12'h0f90, 12'h0100, v);
    chk("app lock", v, 1'b0);
    wb(1'b1, REG_CTRL, 32'h0000_0004, q);
    store_program_instruction(OP_ERASE, 12'h0f90, 12'h0f90, v);
    chk("boot lock", v, 1'b0);
    wb(1'b1, REG_IRQ_MASK, 32'h0, q);
    wb(1'b0, REG_IRQ_STAT, 32'h0, q);
    chk("masked stat", q[1], 1'b1);
    chk("masked irq", irq, 1'b0);
    wb(1'b0, 8'h10, 32'h0, q);
    chk("unmapped", q, 32'h0);
  endtask

  task automatic wrap_up();
    $display("checks %0d, mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  initial begin
    repeat (20) @(posedge clk);
    rstn <= 1'b1;
    wb(1'b1, REG_IRQ_MASK, 32'h0000_0003, q);
    t_app();
    t_rww();
    t_halt();
    t_fuse();
    t_lock();
    wrap_up();
  end

  // The whole run needs under 1500 cycles; this leaves ample margin.
  initial begin
    repeat (5000) @(posedge clk);
    mismatches++;
    wrap_up();
  end
endmodule
